// ==== rtl/adcs_ctrl.sv ====
// control byte decoder and two-wire slave read path of the sampling converter
// Behaviour
// - write byte msb selects setup or configuration
// - setup bit 2 picks bipolar or unipolar
// - setup bit 1 low restores configuration defaults
// - setup bit 0 is ignored
// - setup bit 3 picks conversion clock source
// - configuration bits 6..5 hold scan pattern
// - scan pattern sets conversions per read
// - configuration bit 0 picks single or differential
// - single-ended measures picked input against ground
// - differential pick swaps positive and negative inputs
// - device acks read address then sends data
// - result sent as two bytes, six ones first
// - on nack device releases data line
`timescale 1ns/1ps
module adcs_ctrl
  import adcs_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = adcs_pkg::DEF_ADDR
) (
  input wire logic clk_in, // 50 MHz system clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic ce_in, // clock enable, freezes all state
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive level
  output logic sda_oe_n_out, // low while pulling data low
  input wire logic [adcs_pkg::RES_W-1:0] result_in, // converted result
  input wire logic result_valid_in, // result offered
  output logic result_ready_out, // result buffer has room
  output logic conv_start_out, // pulse: read address accepted
  output logic [2:0] ref_pick_out, // reference select field
  output logic conv_clk_ext_out, // 1: serial clock drives conversion
  output logic polarity_pick_out, // 1: bipolar
  output logic [1:0] scan_pattern_out, // scan pattern field
  output logic input_pick_out, // channel pick bit
  output logic input_topology_out, // 1: single-ended
  output logic [3:0] conv_count_out, // conversions per read, 0 reserved
  output logic [1:0] pos_in_out, // positive input: zero, one
  output logic [1:0] neg_in_out // negative input: zero, one, ground
);
  import adcs_pkg::*;

  // ----------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce_in) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  assign scl_rise = scl_s_q[1] && !scl_p_q;
  assign scl_fall = !scl_s_q[1] && scl_p_q;
  assign bus_start = scl_s_q[1] && scl_p_q && !sda_s_q[1] && sda_p_q;
  assign bus_stop = scl_s_q[1] && scl_p_q && sda_s_q[1] && !sda_p_q;

  // ----------------------------------------
  // result buffer
  // ----------------------------------------
  logic [RES_W-1:0] fifo_data;
  logic fifo_valid;
  logic take_word;
  adcs_fifo #(.W(RES_W), .D(FIFO_D)) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .in_data_in(result_in),
    .in_valid_in(result_valid_in),
    .in_ready_out(result_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(take_word)
  );

  // ----------------------------------------
  // serial state machine
  // ----------------------------------------
  adcs_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic half_q;
  logic ack_q;
  logic [RES_W-1:0] word_q;
  logic [RES_W-1:0] word_now;
  logic wr_dec;
  logic addr_hit;
  assign addr_hit = (rx_q[7:1] == SLAVE_ADDR);
  assign wr_dec = (state_q == ST_WR_BYTE) && scl_fall && (cnt_q == BYTE_BITS);
  // with the buffer dry the last word is sent again rather than garbage
  assign word_now = fifo_valid ? fifo_data : word_q;
  // a read cut off after its first byte leaves half_q set, so the address ack must not test it
  assign take_word = ce_in && scl_fall && fifo_valid &&
    ((state_q == ST_ADDR_ACK && rx_q[0]) || (state_q == ST_RD_ACK && !ack_q && !half_q));

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'hFF;
      half_q <= 1'b0;
      ack_q <= 1'b1;
      word_q <= '0;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      conv_start_out <= 1'b0;
    end else if (ce_in) begin
      conv_start_out <= 1'b0;
      if (bus_start) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_n_out <= 1'b1;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe_n_out <= 1'b1;
          end
          ST_ADDR, ST_WR_BYTE: begin
            if (scl_rise && cnt_q != BYTE_BITS) begin
              rx_q <= {rx_q[6:0], sda_s_q[1]};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BYTE_BITS) begin
              if (state_q == ST_WR_BYTE || addr_hit) begin
                sda_oe_n_out <= 1'b0;
                state_q <= (state_q == ST_ADDR) ? ST_ADDR_ACK : ST_WR_ACK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_n_out <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= ST_WR_BYTE;
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            if (scl_rise && state_q == ST_RD_ACK) ack_q <= sda_s_q[1];
            if (scl_fall) begin
              if (state_q == ST_ADDR_ACK && !rx_q[0]) begin
                sda_oe_n_out <= 1'b1;
                cnt_q <= 4'h0;
                state_q <= ST_WR_BYTE;
              end else if (state_q == ST_RD_ACK && ack_q) begin
                sda_oe_n_out <= 1'b1;
                state_q <= ST_IDLE;
              end else begin
                if (state_q == ST_ADDR_ACK) begin
                  conv_start_out <= 1'b1;
                  half_q <= 1'b0;
                end
                if (!half_q || state_q == ST_ADDR_ACK) begin
                  word_q <= word_now;
                  sda_oe_n_out <= 1'b1;
                  tx_q <= {{6{1'b1}}, word_now[9:8]};
                end else begin
                  sda_oe_n_out <= word_q[7];
                  tx_q <= word_q[7:0];
                end
                cnt_q <= 4'h1;
                state_q <= ST_RD_BYTE;
              end
            end
          end
          ST_RD_BYTE: begin
            if (scl_fall) begin
              if (cnt_q == BYTE_BITS) begin
                sda_oe_n_out <= 1'b1;
                half_q <= !half_q;
                state_q <= ST_RD_ACK;
              end else begin
                sda_oe_n_out <= tx_q[7 - cnt_q[2:0]];
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [2:0] ref_q;
  logic clk_q;
  logic pol_q;
  logic [1:0] scan_q;
  logic pick_q;
  logic topo_q;
  // setup register: bit 0 has no home, so it is dropped
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ref_q <= RST_REF;
      clk_q <= RST_CLK;
      pol_q <= RST_POL;
    end else if (ce_in && wr_dec && rx_q[BIT_REG]) begin
      ref_q <= rx_q[BIT_REF_HI:BIT_REF_LO];
      clk_q <= rx_q[BIT_CLK];
      pol_q <= rx_q[BIT_POL];
    end
  end
  // configuration register: bits 4..2 are don't-care
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      scan_q <= RST_SCAN;
      pick_q <= RST_PICK;
      topo_q <= RST_TOPO;
    end else if (ce_in && wr_dec) begin
      if (rx_q[BIT_REG] && !rx_q[BIT_RST]) begin
        scan_q <= RST_SCAN;
        pick_q <= RST_PICK;
        topo_q <= RST_TOPO;
      end else if (!rx_q[BIT_REG]) begin
        scan_q <= rx_q[BIT_SCAN_HI:BIT_SCAN_LO];
        pick_q <= rx_q[BIT_PICK];
        topo_q <= rx_q[BIT_TOPO];
      end
    end
  end

  // ----------------------------------------
  // steering and scan decode
  // ----------------------------------------
  function automatic logic [3:0] conv_count(input logic [1:0] scan, input logic pick);
    case (scan)
      SCAN_UP: conv_count = {3'h0, pick} + 4'h1;
      SCAN_EIGHT: conv_count = EIGHT_CONV;
      SCAN_ONCE: conv_count = 4'h1;
      default: conv_count = 4'h0;
    endcase
  endfunction
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pos_in_out <= IN_ZERO;
      neg_in_out <= IN_GND;
      conv_count_out <= 4'h1;
    end else if (ce_in) begin
      conv_count_out <= conv_count(scan_q, pick_q);
      pos_in_out <= pick_q ? IN_ONE : IN_ZERO;
      if (topo_q) neg_in_out <= IN_GND;
      else neg_in_out <= pick_q ? IN_ZERO : IN_ONE;
    end
  end
  assign ref_pick_out = ref_q;
  assign conv_clk_ext_out = clk_q;
  assign polarity_pick_out = pol_q;
  assign scan_pattern_out = scan_q;
  assign input_pick_out = pick_q;
  assign input_topology_out = topo_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_setup_fields;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    wr_dec && rx_q[BIT_REG] |=> pol_q == $past(rx_q[BIT_POL]) &&
      clk_q == $past(rx_q[BIT_CLK]);
  endproperty
  a_setup_fields: assert property (p_setup_fields) else $error("setup write lost");
  property p_ref_field;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    wr_dec && rx_q[BIT_REG] |=> ref_q == $past(rx_q[6:4]);
  endproperty
  a_ref_field: assert property (p_ref_field) else $error("reference field wrong");
  property p_cfg_fields;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    wr_dec && !rx_q[BIT_REG] |=> scan_q == $past(rx_q[6:5]) &&
      topo_q == $past(rx_q[0]) && pick_q == $past(rx_q[1]);
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) else $error("config write lost");
  property p_cfg_restore;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    wr_dec && rx_q[BIT_REG] && !rx_q[BIT_RST] |=> scan_q == 2'h0 && topo_q && !pick_q;
  endproperty
  a_cfg_restore: assert property (p_cfg_restore) else $error("config not restored");
  property p_eight;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    scan_q == SCAN_EIGHT ##1 scan_q == SCAN_EIGHT |-> conv_count_out == 4'h8;
  endproperty
  a_eight: assert property (p_eight) else $error("scan count wrong");
  property p_diff_swap;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    !topo_q && pick_q ##1 !topo_q && pick_q |-> pos_in_out == 2'h1 && neg_in_out == 2'h0;
  endproperty
  a_diff_swap: assert property (p_diff_swap) else $error("differential steering wrong");
  property p_addr_ack;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    state_q == ST_ADDR_ACK |-> !sda_oe_n_out;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
  property p_lead_ones;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    state_q == ST_RD_BYTE && !half_q && cnt_q <= LEAD_ONES |-> sda_oe_n_out;
  endproperty
  a_lead_ones: assert property (p_lead_ones) else $error("lead bits not high");
  property p_nack_release;
    @(posedge clk_in) disable iff (!nrst_in || !ce_in)
    state_q == ST_RD_ACK && scl_fall && ack_q && !bus_start |=>
      sda_oe_n_out && state_q == ST_IDLE;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("line held after nack");
endmodule // adcs_ctrl

// ==== rtl/adcs_fifo.sv ====
// result buffer between the converter and the serial read path
`timescale 1ns/1ps
module adcs_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input wire logic clk_in, // system clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic ce_in, // clock enable
  input wire logic [W-1:0] in_data_in, // word to store
  input wire logic in_valid_in, // word offered
  output logic in_ready_out, // room for a word
  output logic [W-1:0] out_data_out, // oldest word
  output logic out_valid_out, // a word is held
  input wire logic out_ready_in // oldest word taken
);
  localparam int AW = $clog2(D);
  initial begin
    if (D < 2 || (1 << AW) != D) $error("adcs_fifo depth must be a power of two >= 2");
  end
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_out <= 1'b1;
    end else if (ce_in) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_d;
      // ready is registered from the next count cnt_d, so it matches the room left in cnt_q with no lag
      in_ready_out <= (cnt_d != (AW+1)'(D));
    end
  end
  always_ff @(posedge clk_in) begin
    if (ce_in && push) mem_q[wr_q] <= in_data_in;
  end
endmodule // adcs_fifo

// ==== rtl/adcs_pkg.sv ====
// shared constants for the converter control bytes and the serial read path
package adcs_pkg;
  // ----------------------------------------
  // byte field positions
  // ----------------------------------------
  localparam int BIT_REG = 7;
  localparam int BIT_REF_HI = 6;
  localparam int BIT_REF_LO = 4;
  localparam int BIT_CLK = 3;
  localparam int BIT_POL = 2;
  localparam int BIT_RST = 1;
  localparam int BIT_SCAN_HI = 6;
  localparam int BIT_SCAN_LO = 5;
  localparam int BIT_PICK = 1;
  localparam int BIT_TOPO = 0;
  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [2:0] RST_REF = 3'h0;
  localparam logic RST_CLK = 1'b0;
  localparam logic RST_POL = 1'b0;
  localparam logic [1:0] RST_SCAN = 2'h0;
  localparam logic RST_PICK = 1'b0;
  localparam logic RST_TOPO = 1'b1;
  // ----------------------------------------
  // encodings and counts
  // ----------------------------------------
  localparam logic [1:0] SCAN_UP = 2'h0;
  localparam logic [1:0] SCAN_EIGHT = 2'h1;
  localparam logic [1:0] SCAN_RSVD = 2'h2;
  localparam logic [1:0] SCAN_ONCE = 2'h3;
  localparam logic [3:0] EIGHT_CONV = 4'h8;
  localparam logic [1:0] IN_ZERO = 2'h0;
  localparam logic [1:0] IN_ONE = 2'h1;
  localparam logic [1:0] IN_GND = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LEAD_ONES = 4'h6;
  localparam int RES_W = 10;
  localparam int FIFO_D = 8;
  // arbitrary neutral slave address, not tied to any part
  localparam logic [6:0] DEF_ADDR = 7'h2A;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK
  } adcs_state_t;
endpackage

// ==== tb/adcs_ctrl_tb.sv ====
// self-checking bench for the converter control and read path
`timescale 1ns/1ps
module adcs_ctrl_tb;
  import adcs_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, scl, m_sda, sda_w, sda_dev, oe_n, res_v = 1'b0, res_rdy, cs;
  logic cke, pol, pick, topo, a;
  logic [9:0] res = 10'h000;
  logic [2:0] refp;
  logic [1:0] scan, pos, neg;
  logic [3:0] cnt;
  logic [7:0] b1, b2;
  logic [9:0] w [8];
  int bad_count = 0, num_checks = 0, starts = 0, cyc = 0;
  // the line has a pull-up: low only when some party pulls it
  assign sda_w = m_sda & (oe_n | sda_dev);
  adcs_ctrl uut (.clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_dev), .sda_oe_n_out(oe_n), .result_in(res), .result_valid_in(res_v),
    .result_ready_out(res_rdy), .conv_start_out(cs), .ref_pick_out(refp),
    .conv_clk_ext_out(cke), .polarity_pick_out(pol), .scan_pattern_out(scan),
    .input_pick_out(pick), .input_topology_out(topo), .conv_count_out(cnt),
    .pos_in_out(pos), .neg_in_out(neg));
  adcs_master m (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cs === 1'b1) starts++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    m.start_c();
    m.send({DEF_ADDR, 1'b0}, a);
    check(a, 1, "write address ack");
    m.send(d, a);
    check(a, 1, "data ack");
    m.stop_c();
  endtask
  task automatic t_reset();
    check(refp, 0, "ref");
    check(cke, 0, "clk src");
    check(pol, 0, "polarity");
    check(scan, 0, "scan");
    check(cnt, 1, "count");
    check(topo, 1, "topology");
    check({pos, neg}, 4'h2, "inputs");
    check(oe_n, 1, "released");
    $display("reset test done");
  endtask
  task automatic t_setup();
    logic [7:0] s [3] = '{8'hDF, 8'hDE, 8'hA3};
    for (int i = 0; i < 3; i++) begin
      wr(s[i]);
      check(refp, s[i][6:4], "ref");
      check(cke, s[i][3], "clk src");
      check(pol, s[i][2], "polarity");
      check(topo, 1, "config kept");
    end
    $display("setup test done");
  endtask
  task automatic t_config();
    logic [1:0] sc;
    logic p, t;
    for (int i = 0; i < 8; i++) begin
      sc = i[1:0];
      p = i[2];
      t = i[0] ^ i[2];
      wr({1'b0, sc, 3'h5, p, t});
      check(scan, sc, "scan");
      check(cnt, sc == 0 ? p + 1 : sc == 1 ? 8 : sc == 2 ? 0 : 1, "count");
      check({pick, topo}, {p, t}, "pick");
      check(pos, p, "positive");
      check(neg, t ? 2 : !p, "negative");
      check(refp, 2, "setup kept");
    end
    $display("config test done");
  endtask
  task automatic t_restore();
    wr(8'h63);
    wr(8'hB9);
    check({scan, pick, topo}, 4'h1, "config restored");
    check({refp, cke, pol}, 5'h0E, "setup stored");
    $display("restore test done");
  endtask
  task automatic t_read();
    m.start_c();
    m.send({DEF_ADDR ^ 7'h01, 1'b1}, a);
    check(a, 0, "foreign address");
    m.stop_c();
    for (int i = 0; i < 8; i++) begin
      w[i] = 10'h155 + i * 10'h07B;
      res <= w[i];
      res_v <= 1'b1;
      do @(posedge clk); while (res_rdy !== 1'b1);
    end
    res_v <= 1'b0;
    repeat (2) @(posedge clk);
    check(res_rdy, 0, "buffer full");
    starts = 0;
    m.start_c();
    m.send({DEF_ADDR, 1'b1}, a);
    check(a, 1, "read address ack");
    for (int i = 0; i < 8; i++) begin
      m.recv(1'b1, b1);
      m.recv(i < 7, b2);
      check(b1, {6'h3F, w[i][9:8]}, "first byte");
      check(b2, w[i][7:0], "second byte");
    end
    check(oe_n, 1, "release on nack");
    // clocks after the nack must find the line left high, not a resent word
    m.recv(1'b0, b1);
    check(b1, 8'hFF, "line idle after nack");
    m.stop_c();
    check(starts, 1, "start pulses");
    check(res_rdy, 1, "buffer drained");
    $display("read test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_setup();
    t_config();
    t_restore();
    t_read();
    give_verdict();
  end
endmodule // adcs_ctrl_tb

// ==== tb/adcs_master.sv ====
// two-wire bus master model facing the converter's serial port
`timescale 1ns/1ps
module adcs_master (
  input wire logic clk_in, // system clock
  input wire logic sda_in, // resolved data line level
  output logic scl_out, // serial clock, 8 system clocks a bit
  output logic sda_out // 0 pulls data low, 1 releases it
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // data moves early in the low phase so it is long settled when scl rises
  task automatic bit_io(input logic b, output logic r);
    scl_out <= 1'b0;
    hold(1);
    sda_out <= b;
    hold(3);
    scl_out <= 1'b1;
    hold(3);
    r = sda_in;
    hold(1);
  endtask
  task automatic start_c();
    scl_out <= 1'b0;
    hold(1);
    sda_out <= 1'b1;
    hold(3);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b0;
    hold(4);
  endtask
  task automatic stop_c();
    scl_out <= 1'b0;
    hold(1);
    sda_out <= 1'b0;
    hold(3);
    scl_out <= 1'b1;
    hold(4);
    sda_out <= 1'b1;
    hold(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule // adcs_master
